// ---- hw/fsr_pkg.sv ----
/*
  Constants shared by the flash suspend/resume/reset sequencer.
  Assumes a 100 MHz system clock; SPI clock is a separate domain.
*/
// Operation
// RULE1: After suspend latency accept resume always, page programs only in erase suspend.
// RULE2: Table of status, reset and no-op commands accepted anytime after suspend.
// RULE3: Program during erase suspend is refused inside the suspended erase region.
// RULE4: Host sets write enable before every page program.
// RULE5: Program started in erase suspend cannot be suspended; finishes before resume.
// RULE6: That program holds write enable and busy high, clears both when done.
// RULE7: Resume sets write enable and busy, clears the suspend flag, restarts.
// RULE8: Host checks no program is running before resuming an erase.
// RULE9: Resumed operation runs to the end or the next suspend.
// RULE10: Host waits resume-to-suspend gap before another suspend.
// RULE11: Resume is ignored while performance enhance mode is active.
// RULE12: No-operation only cancels a pending reset arm.
// RULE13: Reset acts only directly after reset arm; any other command disarms.
// RULE14: Software reset returns to standby with volatile bits at defaults.
// RULE15: Software reset aborts a running program or erase.
// RULE16: Reset recovery is longer after an interrupted program.
// RULE17: No-op, reset arm and reset decode only from the serial input.
// RULE18: Table read: opcode, three address bytes, dummy, data until deselect.
// RULE19: Host keeps select high and write protect raised in high voltage mode.
// RULE20: After power-up: standby, write enable latch cleared.
// RULE21: Power-on reset indication holds logic in reset, no commands.
// RULE22: Host waits supply settle delay after power-up.
// RULE23: Suspend latency then clear write enable and set matching suspend flag.
// RULE24: Program suspend flag is security bit 2, erase suspend flag bit 3.
// RULE25: While suspended, commands not accepted for that suspend type are ignored.
// RULE26: Suspended region is neither programmed nor exposed by reads.
package fsr_pkg;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_CONFIG_READ = 8'h15;
  localparam logic [7:0] CMD_SECURITY_READ = 8'h2B;
  localparam logic [7:0] CMD_SIGNATURE_READ = 8'hAB;
  localparam logic [7:0] CMD_RESET_ARM = 8'h66;
  localparam logic [7:0] CMD_RESET = 8'h99;
  localparam logic [7:0] CMD_NO_OPERATION = 8'h00;
  localparam logic [7:0] CMD_RESUME_A = 8'h7A;
  localparam logic [7:0] CMD_RESUME_B = 8'h30;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM = 8'h38;
  localparam logic [7:0] CMD_PARAM_TABLE_READ = 8'h5A;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;
  localparam int SEC_PSB_BIT = 2;
  localparam int SEC_ESB_BIT = 3;
  localparam logic [2:0] ADDR_BYTES = 3'd3;
  localparam logic [2:0] DUMMY_BYTES = 3'd1;
  localparam int SYS_CLK_NS = 10;
  localparam int PROG_SUSP_LAT_NS = 20000;
  localparam int ERASE_SUSP_LAT_NS = 20000;
  localparam int PROG_TIME_NS = 1000000;
  localparam int ERASE_TIME_NS = 30000000;
  localparam int RECOV_PROG_NS = 80000;
  localparam int RECOV_OTHER_NS = 40000;
  localparam int PROG_SUSP_LAT_CYC = (PROG_SUSP_LAT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int ERASE_SUSP_LAT_CYC = (ERASE_SUSP_LAT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int PROG_TIME_CYC = (PROG_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int ERASE_TIME_CYC = (ERASE_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int RECOV_PROG_CYC = (RECOV_PROG_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int RECOV_OTHER_CYC = (RECOV_OTHER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PROGRAM = 3'b001,
    ST_ERASE = 3'b010,
    ST_SUSPENDING = 3'b011,
    ST_SUSPENDED = 3'b100,
    ST_PROG_ESUSP = 3'b101,
    ST_RECOVERY = 3'b110
  } fsr_state_e;
  typedef enum logic [1:0] {
    RG_PAGE = 2'b00,
    RG_SECTOR = 2'b01,
    RG_BLOCK = 2'b10
  } fsr_region_e;
endpackage

// ---- hw/fsr_sequencer.sv ----
/*
  Suspend, resume and software reset sequencer of a serial NOR flash.
  Assumes the array is driven by the op start/abort ports.
*/
`timescale 1ns/10ps
module fsr_sequencer
  import fsr_pkg::*;
#(
  parameter logic [31:0] PROG_CYC = 32'(PROG_TIME_CYC),
  parameter logic [31:0] ERASE_CYC = 32'(ERASE_TIME_CYC),
  parameter logic [31:0] PSL_CYC = 32'(PROG_SUSP_LAT_CYC),
  parameter logic [31:0] ESL_CYC = 32'(ERASE_SUSP_LAT_CYC),
  parameter logic [31:0] RECP_CYC = 32'(RECOV_PROG_CYC),
  parameter logic [31:0] RECO_CYC = 32'(RECOV_OTHER_CYC)
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic porActive,
  input wire logic sclk,
  input wire logic csN,
  input wire logic si,
  output logic so,
  output logic soOeN,
  input wire logic perfEnhanceMode,
  input wire logic protectAll,
  output logic writeEnableLatch,
  output logic writeInProgress,
  output logic programSuspendFlag,
  output logic eraseSuspendFlag,
  output logic [7:0] securityReg,
  output logic standby,
  output logic arrayOpStart,
  output logic arrayOpAbort,
  output logic [23:0] arrayOpAddr,
  output logic readRegionHidden
);
  localparam logic [7:0] PARAM_TABLE [16] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01, 8'hFF,
    8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF
  };

  logic rawRstn;
  logic [1:0] rstSync_q;
  logic sysRstn;
  assign rawRstn = rstn & ~porActive; // RULE21
  always_ff @(posedge clk_sys or negedge rawRstn) begin
    if (!rawRstn) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign sysRstn = rstSync_q[1];

  logic [7:0] txByte_q;
  logic [7:0] linkRxByte;
  logic linkRxTog;
  fsr_spi_link uLink (
    .sclk(sclk), .rstn(sysRstn),
    .csN(csN),
    .si(si),
    .txByte(txByte_q),
    .rxByte(linkRxByte),
    .rxToggle(linkRxTog),
    .so(so),
    .soOeN(soOeN)
  );

  logic [1:0] syncOut;
  fsr_sync #(.WIDTH(2), .RESET_VAL(2'b10)) uSync (
    .clk(clk_sys),
    .rstn(sysRstn),
    .din({csN, linkRxTog}),
    .dout(syncOut)
  );

  logic togSeen_q;
  logic csPrev_q;
  logic execPend_q;
  logic rxEvent;
  logic frameStart;
  logic frameEnd;
  assign rxEvent = syncOut[0] ^ togSeen_q;
  assign frameStart = ~syncOut[1] & csPrev_q;
  assign frameEnd = syncOut[1] & ~csPrev_q;
  // Execution waits one cycle so a last byte racing deselect lands first
  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      togSeen_q <= 1'b0;
      csPrev_q <= 1'b1;
      execPend_q <= 1'b0;
    end else begin
      togSeen_q <= syncOut[0];
      csPrev_q <= syncOut[1];
      execPend_q <= frameEnd;
    end
  end

  logic [7:0] opcode_q;
  logic [2:0] byteCnt_q;
  logic [23:0] addr_q;
  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      opcode_q <= CMD_NO_OPERATION;
      byteCnt_q <= 3'd0;
      addr_q <= 24'h000000;
    end else if (frameStart) begin
      byteCnt_q <= 3'd0;
    end else if (rxEvent) begin
      if (byteCnt_q == 3'd0) begin
        opcode_q <= linkRxByte;
      end else if (byteCnt_q <= ADDR_BYTES) begin
        addr_q <= {addr_q[15:0], linkRxByte};
      end
      if (byteCnt_q != 3'd7) begin
        byteCnt_q <= byteCnt_q + 3'd1;
      end
    end
  end

  fsr_state_e state_q;
  fsr_region_e heldRg_q;
  logic [23:0] heldAddr_q;
  logic [31:0] opTimer_q;
  logic [31:0] auxTimer_q;
  logic kindErase_q;
  logic wel_q;
  logic wip_q;
  logic psb_q;
  logic esb_q;
  logic arm_q;

  function automatic logic inRegion(input logic [23:0] a);
    case (heldRg_q)
      RG_PAGE: inRegion = a[23:8] == heldAddr_q[23:8];
      RG_SECTOR: inRegion = a[23:12] == heldAddr_q[23:12];
      default: inRegion = a[23:16] == heldAddr_q[23:16];
    endcase
  endfunction

  logic cmdGo;
  logic isProg;
  logic isErase;
  logic suspended;
  logic busyOp;
  logic rstGo;
  logic wrenGo;
  logic wrdiGo;
  logic progGo;
  logic eraseGo;
  logic suspGo;
  logic resumeGo;
  logic opDone;
  logic latDone;
  logic espDone;
  logic recDone;
  // No command takes effect during reset recovery; read data is still returned
  assign cmdGo = execPend_q && byteCnt_q != 3'd0 && state_q != ST_RECOVERY;
  assign isProg = opcode_q == CMD_PAGE_PROGRAM || opcode_q == CMD_QUAD_PAGE_PROGRAM;
  assign isErase = opcode_q == CMD_SECTOR_ERASE || opcode_q == CMD_BLOCK_ERASE;
  assign suspended = state_q == ST_SUSPENDED;
  assign busyOp = state_q == ST_PROGRAM || state_q == ST_ERASE || state_q == ST_PROG_ESUSP;
  assign rstGo = cmdGo && opcode_q == CMD_RESET && arm_q; // RULE13
  // Write enable also counts during an erase suspend
  assign wrenGo = cmdGo && opcode_q == CMD_WRITE_ENABLE
    && (state_q == ST_IDLE || (suspended && esb_q)); // RULE25
  assign wrdiGo = cmdGo && opcode_q == CMD_WRITE_DISABLE
    && (state_q == ST_IDLE || suspended || state_q == ST_SUSPENDING); // RULE2
  assign progGo = cmdGo && isProg && wel_q && !protectAll // RULE4
    && byteCnt_q > ADDR_BYTES + 3'd1
    && (state_q == ST_IDLE || (suspended && esb_q && !inRegion(addr_q))); // RULE1 RULE3
  assign eraseGo = cmdGo && isErase && wel_q && !protectAll
    && byteCnt_q > ADDR_BYTES && state_q == ST_IDLE;
  // No suspend from a program started inside an erase suspend
  assign suspGo = cmdGo && opcode_q == CMD_SUSPEND
    && (state_q == ST_PROGRAM || state_q == ST_ERASE); // RULE5
  assign resumeGo = cmdGo && (opcode_q == CMD_RESUME_A || opcode_q == CMD_RESUME_B)
    && suspended && !perfEnhanceMode; // RULE1 RULE11 RULE5
  assign opDone = (state_q == ST_PROGRAM || state_q == ST_ERASE) && opTimer_q == 32'd1;
  assign latDone = state_q == ST_SUSPENDING && auxTimer_q == 32'd1;
  assign espDone = state_q == ST_PROG_ESUSP && auxTimer_q == 32'd1;
  assign recDone = state_q == ST_RECOVERY && auxTimer_q == 32'd1;

  // Any decoded frame other than a reset arm, no-op included, drops a pending arm
  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      arm_q <= 1'b0;
    end else if (cmdGo) begin
      arm_q <= opcode_q == CMD_RESET_ARM; // RULE12 RULE13 RULE17
    end
  end

  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      state_q <= ST_IDLE; // RULE20
      opTimer_q <= 32'd0;
      auxTimer_q <= 32'd0;
      kindErase_q <= 1'b0;
      heldRg_q <= RG_PAGE;
      heldAddr_q <= 24'h000000;
    end else if (rstGo) begin
      state_q <= ST_RECOVERY; // RULE14
      auxTimer_q <= (state_q == ST_PROGRAM || state_q == ST_PROG_ESUSP)
        ? RECP_CYC : RECO_CYC; // RULE16
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (progGo) begin
            state_q <= ST_PROGRAM;
            opTimer_q <= PROG_CYC;
            kindErase_q <= 1'b0;
            heldRg_q <= RG_PAGE;
            heldAddr_q <= addr_q;
          end else if (eraseGo) begin
            state_q <= ST_ERASE;
            opTimer_q <= ERASE_CYC;
            kindErase_q <= 1'b1;
            heldRg_q <= opcode_q == CMD_SECTOR_ERASE ? RG_SECTOR : RG_BLOCK;
            heldAddr_q <= addr_q;
          end
        end
        ST_PROGRAM, ST_ERASE: begin
          if (opDone) begin
            state_q <= ST_IDLE;
          end else if (suspGo) begin
            state_q <= ST_SUSPENDING;
            auxTimer_q <= kindErase_q ? ESL_CYC : PSL_CYC; // RULE23
          end
          opTimer_q <= opTimer_q - 32'd1; // RULE9
        end
        ST_SUSPENDING: begin
          if (latDone) begin
            state_q <= ST_SUSPENDED;
          end
          auxTimer_q <= auxTimer_q - 32'd1;
        end
        ST_SUSPENDED: begin
          if (resumeGo) begin
            state_q <= kindErase_q ? ST_ERASE : ST_PROGRAM; // RULE9
          end else if (progGo) begin
            state_q <= ST_PROG_ESUSP;
            auxTimer_q <= PROG_CYC;
          end
        end
        ST_PROG_ESUSP: begin
          if (espDone) begin
            state_q <= ST_SUSPENDED; // RULE5
          end
          auxTimer_q <= auxTimer_q - 32'd1;
        end
        ST_RECOVERY: begin
          if (recDone) begin
            state_q <= ST_IDLE;
          end
          auxTimer_q <= auxTimer_q - 32'd1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      wel_q <= 1'b0; // RULE20
    end else if (rstGo || wrdiGo || opDone || espDone || latDone) begin
      wel_q <= 1'b0; // RULE6 RULE14 RULE23
    end else if (wrenGo || resumeGo) begin
      wel_q <= 1'b1; // RULE7
    end
  end

  // Busy covers the suspend latency and reset recovery as well
  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      wip_q <= 1'b0;
    end else if (rstGo || progGo || eraseGo || resumeGo) begin
      wip_q <= 1'b1; // RULE6 RULE7
    end else if (opDone || espDone || latDone || recDone) begin
      wip_q <= 1'b0; // RULE6
    end
  end

  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      psb_q <= 1'b0;
      esb_q <= 1'b0;
    end else if (rstGo || resumeGo) begin
      psb_q <= 1'b0; // RULE7 RULE14
      esb_q <= 1'b0;
    end else if (latDone) begin
      psb_q <= ~kindErase_q; // RULE23
      esb_q <= kindErase_q;
    end
  end

  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      arrayOpStart <= 1'b0;
      arrayOpAbort <= 1'b0;
      arrayOpAddr <= 24'h000000;
    end else begin
      arrayOpStart <= progGo || eraseGo || resumeGo;
      arrayOpAbort <= rstGo && (busyOp || state_q == ST_SUSPENDING); // RULE15
      if (progGo || eraseGo) begin
        arrayOpAddr <= addr_q;
      end
    end
  end

  // Reads into the held page, sector or block are masked while suspended
  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      readRegionHidden <= 1'b0;
    end else begin
      readRegionHidden <= (psb_q || esb_q) && !syncOut[1]
        && byteCnt_q > ADDR_BYTES && inRegion(addr_q); // RULE26
    end
  end

  logic [3:0] tblIdx_q;
  logic [7:0] curOp;
  assign curOp = byteCnt_q == 3'd0 ? linkRxByte : opcode_q;
  always_ff @(posedge clk_sys or negedge sysRstn) begin
    if (!sysRstn) begin
      txByte_q <= 8'h00;
      tblIdx_q <= 4'h0;
    end else if (rxEvent) begin
      case (curOp)
        CMD_STATUS_READ: txByte_q <= {6'b000000, wel_q, wip_q};
        CMD_SECURITY_READ: txByte_q <= securityReg;
        CMD_PARAM_TABLE_READ: begin
          if (byteCnt_q == ADDR_BYTES + DUMMY_BYTES) begin
            txByte_q <= PARAM_TABLE[addr_q[3:0]]; // RULE18
            tblIdx_q <= addr_q[3:0] + 4'h1;
          end else if (byteCnt_q > ADDR_BYTES + DUMMY_BYTES) begin
            txByte_q <= PARAM_TABLE[tblIdx_q];
            tblIdx_q <= tblIdx_q + 4'h1;
          end else begin
            txByte_q <= 8'h00;
          end
        end
        default: txByte_q <= 8'h00;
      endcase
    end
  end

  always_comb begin
    securityReg = 8'h00;
    securityReg[SEC_PSB_BIT] = psb_q; // RULE24
    securityReg[SEC_ESB_BIT] = esb_q;
  end
  assign writeEnableLatch = wel_q;
  assign writeInProgress = wip_q;
  assign programSuspendFlag = psb_q;
  assign eraseSuspendFlag = esb_q;
  assign standby = state_q == ST_IDLE;

  a_resume_sets_bits: assert property ( // RULE7
    @(posedge clk_sys) disable iff (!sysRstn)
    resumeGo |=> wel_q && wip_q && !psb_q && !esb_q && busyOp)
    else $error("resume did not set busy bits");
  a_suspend_flags_set: assert property ( // RULE23
    @(posedge clk_sys) disable iff (!sysRstn)
    state_q == ST_SUSPENDING && auxTimer_q == 32'd1 |=> !wel_q && (psb_q ^ esb_q))
    else $error("suspend flags wrong after latency");
  a_perf_blocks_resume: assert property ( // RULE11
    @(posedge clk_sys) disable iff (!sysRstn)
    suspended && cmdGo && perfEnhanceMode && !rstGo && !progGo |=> suspended)
    else $error("resume taken in enhance mode");
  a_esusp_prog_bits: assert property ( // RULE6
    @(posedge clk_sys) disable iff (!sysRstn)
    state_q == ST_PROG_ESUSP && !$past(rstGo) |-> wel_q && wip_q && esb_q)
    else $error("bits low during suspend program");
  a_esusp_prog_end: assert property ( // RULE5
    @(posedge clk_sys) disable iff (!sysRstn)
    espDone && !rstGo |=> suspended && !wel_q && !wip_q)
    else $error("suspend program end wrong");
  a_reset_needs_arm: assert property ( // RULE13
    @(posedge clk_sys) disable iff (!sysRstn)
    $rose(state_q == ST_RECOVERY) |-> $past(arm_q))
    else $error("reset without arm");
  a_reset_clears_bits: assert property ( // RULE14
    @(posedge clk_sys) disable iff (!sysRstn)
    state_q == ST_RECOVERY |-> !wel_q && !psb_q && !esb_q)
    else $error("reset left volatile bits");
  a_reset_aborts_op: assert property ( // RULE15
    @(posedge clk_sys) disable iff (!sysRstn)
    rstGo && busyOp |=> arrayOpAbort ##1 !arrayOpAbort)
    else $error("abort pulse missing");
  a_nop_only_disarms: assert property ( // RULE12
    @(posedge clk_sys) disable iff (!sysRstn)
    cmdGo && opcode_q == CMD_NO_OPERATION && state_q == ST_IDLE
    |=> !arm_q && $stable(wel_q) && state_q == ST_IDLE)
    else $error("no-op changed state");
  a_region_no_program: assert property ( // RULE3
    @(posedge clk_sys) disable iff (!sysRstn)
    suspended && cmdGo && isProg && inRegion(addr_q) && !rstGo |=> suspended)
    else $error("program in suspended region");
endmodule

// ---- hw/fsr_spi_link.sv ----
/*
  Serial front end on the SPI clock: shifts bytes in, bytes out.
  Assumes mode 0 framing; chip select high clears the frame.
*/
`timescale 1ns/10ps
module fsr_spi_link (
  input wire logic sclk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic si,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte,
  output logic rxToggle,
  output logic so,
  output logic soOeN
);
  logic [2:0] bitCnt_q;
  logic [6:0] rxShift_q;
  logic [7:0] txShift_q;
  logic started_q;
  // Clock may stop between frames, so deselect clears the bit count and the shift register
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitCnt_q <= 3'd0;
      rxShift_q <= 7'h00;
    end else begin
      rxShift_q <= {rxShift_q[5:0], si}; // RULE17
      bitCnt_q <= bitCnt_q + 3'd1;
    end
  end
  // Byte and toggle survive deselect so the last byte still crosses
  // Reset is released while the clock stands still between frames
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      rxByte <= 8'h00;
      rxToggle <= 1'b0;
    end else if (!csN && bitCnt_q == 3'd7) begin
      rxByte <= {rxShift_q, si};
      rxToggle <= ~rxToggle;
    end
  end
  // Next byte is loaded on the falling edge ending a byte; the system side
  // needs about four clk_sys cycles before that edge
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      txShift_q <= 8'h00;
      started_q <= 1'b0;
    end else if (bitCnt_q == 3'd0) begin
      txShift_q <= txByte; // RULE18
      started_q <= 1'b1;
    end else begin
      txShift_q <= {txShift_q[6:0], 1'b0};
    end
  end
  assign so = txShift_q[7];
  assign soOeN = csN | ~started_q;
endmodule

// ---- hw/fsr_sync.sv ----
/*
  Two-flop level synchroniser, one chain per bit.
  Assumes inputs are levels or toggles slower than the clock.
*/
`timescale 1ns/10ps
module fsr_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_q[i] <= RESET_VAL[i];
          dout[i] <= RESET_VAL[i];
        end else begin
          meta_q[i] <= din[i];
          dout[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule

// ---- verif/fsr_host_model.sv ----
/*
  Host side of the serial link: frames bytes MSB first, mode 0.
  Assumes the bench calls frame() and waits for it to return.
*/
`timescale 1ns/10ps
module fsr_host_model (
  output logic sclk,
  output logic csN,
  output logic si,
  input wire logic so,
  input wire logic soOeN
);
  // Extra select-high time the host keeps while high voltage settles
  int hvSettleNs = 0;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    si = 1'b0;
  end

  // Byte k is tx[47-8k -: 8]; the clock stands still between frames
  task automatic frame(input logic [47:0] tx, input int n, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    #(37 + hvSettleNs) csN = 1'b0;
    for (i = 0; i < n * 8; i++) begin
      si = tx[47 - i];
      #80 sclk = 1'b1;
      rx = {rx[6:0], soOeN ? ~rx[0] : so};
      #80 sclk = 1'b0;
    end
    #80 csN = 1'b1;
    // Deselected line must not look like held data
    si = ~si;
  endtask
endmodule

// ---- verif/test_flash_suspend_resume_reset.sv ----
/*
  Self-checking bench for the suspend, resume and reset sequencer.
  Assumes the host model drives the link with shortened op times.
*/
`timescale 1ns/10ps
module test_flash_suspend_resume_reset;
  import fsr_pkg::*;
  localparam int RECP = 600;
  localparam int RECO = 300;
  localparam int RS_GAP = 40;
  logic protectAll = 1'b0;
  logic hidden, startPulse;
  logic hidSeen = 1'b0;
  int startCnt = 0;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic porActive = 1'b0;
  logic perfEnhanceMode = 1'b0;
  logic sclk, csN, si, so, soOeN;
  logic write_enable_cmd, busy, pSusp, eSusp, standby, opAbort;
  logic [7:0] secReg;
  logic [7:0] rxB;
  logic [23:0] opAddr;
  int fail_count = 0;
  int compares = 0;
  wire logic [7:0] flags = {4'h0, write_enable_cmd, busy, pSusp, eSusp};

  always #5 clk_sys = ~clk_sys;

  // Sticky record of the hidden-region flag and a count of array starts
  always @(posedge clk_sys) begin
    if (hidden === 1'b1) begin
      hidSeen <= 1'b1;
    end
    if (startPulse === 1'b1) begin
      startCnt <= startCnt + 1;
    end
  end

  fsr_host_model host_u (.sclk(sclk), .csN(csN), .si(si), .so(so), .soOeN(soOeN));

  fsr_sequencer #(.PROG_CYC(32'd2000), .ERASE_CYC(32'd4000), .PSL_CYC(32'd20),
    .RECP_CYC(32'd600), .RECO_CYC(32'd300)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .porActive(porActive), .sclk(sclk), .csN(csN),
    .si(si), .so(so), .soOeN(soOeN), .perfEnhanceMode(perfEnhanceMode),
    .protectAll(protectAll), .writeEnableLatch(write_enable_cmd), .writeInProgress(busy),
    .programSuspendFlag(pSusp), .eraseSuspendFlag(eSusp), .securityReg(secReg),
    .standby(standby), .arrayOpStart(startPulse), .arrayOpAbort(opAbort),
    .arrayOpAddr(opAddr), .readRegionHidden(hidden));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chkF(input logic [7:0] e);
    chk("flags", {24'h0, e}, {24'h0, flags});
  endtask

  task automatic cmd(input logic [7:0] op, input logic [39:0] a, input int n);
    host_u.frame({op, a}, n, rxB);
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic waitIdle(input int lim);
    int i;
    for (i = 0; i < lim && busy !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic recov(input int exp);
    int i;
    int n;
    n = 0;
    cmd(CMD_RESET_ARM, 0, 1);
    host_u.frame({CMD_RESET, 40'h0}, 1, rxB);
    for (i = 0; i < 20 && opAbort !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("abort", 1, {31'h0, opAbort});
    while (n < 2000 && standby !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("recovery", 1, {31'h0, n >= exp - 2 && n <= exp + 4});
    chkF(8'h00);
    chk("security", 0, {24'h0, secReg});
  endtask

  task automatic t_power;
    @(posedge clk_sys);
    porActive <= 1'b1;
    cmd(CMD_WRITE_ENABLE, 0, 1);
    chkF(8'h00);
    porActive <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("standby", 1, {31'h0, standby});
    chkF(8'h00);
  endtask

  task automatic t_psusp;
    cmd(CMD_WRITE_ENABLE, 0, 1);
    cmd(CMD_PAGE_PROGRAM, 40'h000100A500, 5);
    chkF(8'h0C);
    chk("address", 24'h000100, {8'h0, opAddr});
    cmd(CMD_SUSPEND, 0, 1);
    repeat (25) @(posedge clk_sys);
    chkF(8'h02);
    cmd(CMD_SECURITY_READ, 0, 2);
    chk("security read", 8'h04, {24'h0, rxB});
    cmd(CMD_STATUS_READ, 0, 2);
    chk("status read", 8'h00, {24'h0, rxB});
    cmd(CMD_WRITE_ENABLE, 0, 1);
    chkF(8'h02);
    perfEnhanceMode <= 1'b1;
    cmd(CMD_RESUME_A, 0, 1);
    chkF(8'h02);
    perfEnhanceMode <= 1'b0;
    cmd(CMD_RESUME_B, 0, 1);
    chkF(8'h0C);
    repeat (RS_GAP) @(posedge clk_sys);
    cmd(CMD_SUSPEND, 0, 1);
    repeat (25) @(posedge clk_sys);
    chkF(8'h02);
    cmd(CMD_RESUME_A, 0, 1);
    waitIdle(2100);
    chkF(8'h00);
    chk("starts", 3, startCnt);
  endtask

  task automatic t_esusp;
    cmd(CMD_WRITE_ENABLE, 0, 1);
    cmd(CMD_SECTOR_ERASE, 40'h0010000000, 4);
    cmd(CMD_SUSPEND, 0, 1);
    repeat (ERASE_SUSP_LAT_CYC + 5) @(posedge clk_sys);
    chkF(8'h01);
    cmd(CMD_PARAM_TABLE_READ, 40'h0000010000, 6);
    chk("table", 8'h46, {24'h0, rxB});
    chk("hidden", 0, {31'h0, hidSeen});
    cmd(CMD_WRITE_ENABLE, 0, 1);
    cmd(CMD_PAGE_PROGRAM, 40'h001010A500, 5);
    chkF(8'h09);
    chk("hidden", 1, {31'h0, hidSeen});
    cmd(CMD_WRITE_ENABLE, 0, 1);
    cmd(CMD_QUAD_PAGE_PROGRAM, 40'h002000A500, 5);
    chkF(8'h0D);
    cmd(CMD_SUSPEND, 0, 1);
    repeat (25) @(posedge clk_sys);
    chkF(8'h0D);
    waitIdle(2100);
    chkF(8'h01);
    cmd(CMD_RESUME_A, 0, 1);
    chkF(8'h0C);
    chk("starts", 6, startCnt);
    cmd(CMD_RESET_ARM, 0, 1);
    cmd(CMD_NO_OPERATION, 0, 1);
    cmd(CMD_RESET, 0, 1);
    chkF(8'h0C);
    cmd(CMD_RESET_ARM, 0, 1);
    cmd(CMD_STATUS_READ, 0, 1);
    cmd(CMD_RESET, 0, 1);
    chkF(8'h0C);
    recov(RECO);
  endtask

  task automatic t_preset;
    protectAll <= 1'b1;
    cmd(CMD_WRITE_ENABLE, 0, 1);
    cmd(CMD_PAGE_PROGRAM, 40'h000300A500, 5);
    chkF(8'h08);
    protectAll <= 1'b0;
    cmd(CMD_PAGE_PROGRAM, 40'h000300A500, 5);
    chkF(8'h0C);
    recov(RECP);
  endtask

  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_power;
    t_psusp;
    t_esusp;
    t_preset;
    end_of_test;
  end

  // Whole run needs about 0.15 ms; the limit leaves room but stays bounded
  initial begin
    #600000;
    fail_count++;
    end_of_test;
  end
endmodule
